// ### logic/ddrw_top.sv
// Purpose: Device-side receiver for DDR write bursts and bank sequencing.
// Assumes: Link clock far slower than core clock; all pins sampled.
// Notes: Captured elements leave as words through a four-deep FIFO.
`default_nettype none

module ddrw_top
  import ddrw_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Link command pins
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  // Link data pins
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic dm,
  // Static configuration
  input wire logic [1:0] bl_code,
  input wire logic interleave,
  // Written element stream
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [DQ_W-1:0] wr_data,
  output logic [BA_W-1:0] wr_bank,
  output logic [ADDR_W-1:0] wr_row,
  output logic [COL_W-1:0] wr_col,
  // Status
  output logic [NBANK-1:0] bank_open,
  output logic write_active,
  output logic read_active,
  output logic cmd_err,
  output logic fifo_drop
);
  typedef struct packed {
    pins_s s1;
    pins_s s2;
    logic prev_ck;
    logic prev_dqs;
    logic [NBANK-1:0] bank_open;
    logic [NBANK-1:0][ADDR_W-1:0] row;
    logic [NBANK-1:0][CNT_W-1:0] ras_cnt;
    logic q_valid;
    logic q_armed;
    logic [BA_W-1:0] q_bank;
    logic [COL_W-1:0] q_col;
    logic q_ap;
    logic w_active;
    logic [BA_W-1:0] w_bank;
    logic [COL_W-1:0] w_col;
    logic w_ap;
    logic [CNT_W-1:0] w_idx;
    logic [CNT_W-1:0] w_len;
    logic ap_busy;
    logic [BA_W-1:0] ap_bank;
    logic [CNT_W-1:0] ap_cnt;
    logic [CNT_W-1:0] rd_left;
    logic rd_ap;
    logic [BA_W-1:0] rd_bank;
    logic [CNT_W-1:0] rd_half;
    logic [CNT_W-1:0] rd_cnt;
    logic cmd_err;
    logic drop;
    logic pin_oe;
  } st_s;

  st_s r_reg, r_next;
  pins_s pins_now;
  logic ck_rise, ck_fall, dqs_rise, dqs_fall, cmd_ok;
  logic start_ev, take, push, push_ready, cut, wdone_ap;
  logic [CNT_W-1:0] idx, len;
  logic [BA_W-1:0] cap_bank;
  logic [COL_W-1:0] cap_base;
  logic cap_ap;
  logic [WORD_W-1:0] push_word, pop_word;
  function automatic logic [CNT_W-1:0] bl_len(input logic [1:0] code);
    unique case (code)
      BL_CODE_4: return BL_4;
      BL_CODE_8: return BL_8;
      default: return BL_2;
    endcase
  endfunction
  // Column of element i within the burst window, per burst order
  function automatic logic [COL_W-1:0] elem_col(
    input logic [COL_W-1:0] base,
    input logic [CNT_W-1:0] i,
    input logic [CNT_W-1:0] n,
    input logic ilv
  );
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] lo;
    m = COL_W'(n) - 1'b1;
    lo = ilv ? ((base ^ COL_W'(i)) & m) : (COL_W'(base + COL_W'(i)) & m);
    return (base & ~m) | lo;
  endfunction
  assign pins_now = '{ck: ck, cke: cke, cmd: {cs_n, ras_n, cas_n, we_n},
                      ba: ba, addr: addr, dqs: dqs_in, dq: dq_in, dm: dm};
  // Edges seen on the second sync stage only
  assign ck_rise = r_reg.s2.ck && !r_reg.prev_ck;
  assign ck_fall = !r_reg.s2.ck && r_reg.prev_ck;
  assign dqs_rise = r_reg.s2.dqs && !r_reg.prev_dqs;
  assign dqs_fall = !r_reg.s2.dqs && r_reg.prev_dqs;
  assign cmd_ok = ck_rise && r_reg.s2.cke;
  always_comb begin
    r_next = r_reg;
    start_ev = 1'b0;
    take = 1'b0;
    push = 1'b0;
    cut = 1'b0;
    wdone_ap = 1'b0;
    r_next.s1 = pins_now;
    r_next.s2 = r_reg.s1;
    r_next.prev_ck = r_reg.s2.ck;
    r_next.prev_dqs = r_reg.s2.dqs;
    r_next.cmd_err = 1'b0;
    r_next.drop = 1'b0;
    r_next.pin_oe = 1'b0;
    for (int b = 0; b < NBANK; b++) begin
      if (r_reg.ras_cnt[b] < CNT_W'(TRAS_CYC)) begin
        r_next.ras_cnt[b] = CNT_W'(r_reg.ras_cnt[b] + 1'b1);
      end
    end
    if (r_reg.ap_busy) begin
      if (r_reg.ap_cnt >= CNT_W'(TWR_CYC)) begin
        r_next.ap_busy = 1'b0;
        r_next.bank_open[r_reg.ap_bank] = 1'b0;
      end else begin
        r_next.ap_cnt = CNT_W'(r_reg.ap_cnt + 1'b1);
      end
    end
    if (r_reg.rd_ap && r_reg.rd_cnt >= r_reg.rd_half &&
        r_reg.ras_cnt[r_reg.rd_bank] >= CNT_W'(TRAS_CYC)) begin
      r_next.rd_ap = 1'b0;
      r_next.bank_open[r_reg.rd_bank] = 1'b0;
    end
    if (dqs_rise && r_reg.q_valid && r_reg.q_armed) begin
      start_ev = 1'b1;
      r_next.q_valid = 1'b0;
      r_next.w_active = 1'b1;
      r_next.w_bank = r_reg.q_bank;
      r_next.w_col = r_reg.q_col;
      r_next.w_ap = r_reg.q_ap;
      r_next.w_len = bl_len(bl_code);
    end
    idx = start_ev ? '0 : r_reg.w_idx;
    len = start_ev ? bl_len(bl_code) : r_reg.w_len;
    cap_bank = start_ev ? r_reg.q_bank : r_reg.w_bank;
    cap_base = start_ev ? r_reg.q_col : r_reg.w_col;
    cap_ap = start_ev ? r_reg.q_ap : r_reg.w_ap;
    take = start_ev || (r_reg.w_active && (dqs_rise || dqs_fall));
    if (take) begin
      push = !r_reg.s2.dm;
      if (push && !push_ready) begin
        r_next.drop = 1'b1;
      end
      r_next.w_idx = CNT_W'(idx + 1'b1);
      if (CNT_W'(idx + 1'b1) == len) begin
        r_next.w_active = 1'b0;
        if (cap_ap) begin
          wdone_ap = 1'b1;
          r_next.ap_busy = 1'b1;
          r_next.ap_bank = cap_bank;
          r_next.ap_cnt = '0;
        end
      end
    end
    if (ck_fall && r_reg.q_valid) begin
      r_next.q_armed = 1'b1;
    end
    if (cmd_ok) begin
      if (r_reg.rd_left != '0) begin
        r_next.rd_left = CNT_W'(r_reg.rd_left - 1'b1);
      end
      if (r_reg.rd_ap && r_reg.rd_cnt < r_reg.rd_half) begin
        r_next.rd_cnt = CNT_W'(r_reg.rd_cnt + 1'b1);
      end
      case (r_reg.s2.cmd)
        CMD_ACT: begin
          r_next.bank_open[r_reg.s2.ba] = 1'b1;
          r_next.row[r_reg.s2.ba] = r_reg.s2.addr;
          r_next.ras_cnt[r_reg.s2.ba] = '0;
        end
        CMD_WRITE: begin
          if (!r_reg.bank_open[r_reg.s2.ba]) begin
            r_next.cmd_err = 1'b1;
          end else begin
            r_next.q_valid = 1'b1;
            r_next.q_armed = 1'b0;
            r_next.q_bank = r_reg.s2.ba;
            r_next.q_col = r_reg.s2.addr[COL_W-1:0];
            r_next.q_ap = r_reg.s2.addr[AP_BIT];
          end
        end
        CMD_READ: begin
          if (!r_reg.bank_open[r_reg.s2.ba]) begin
            r_next.cmd_err = 1'b1;
          end else begin
            cut = r_reg.w_active || r_reg.q_valid;
            r_next.w_active = 1'b0;
            r_next.q_valid = 1'b0;
            r_next.rd_half = CNT_W'(bl_len(bl_code) >> 1);
            r_next.rd_left = CNT_W'(bl_len(bl_code) >> 1);
            r_next.rd_bank = r_reg.s2.ba;
            r_next.rd_ap = r_reg.s2.addr[AP_BIT];
            r_next.rd_cnt = '0;
          end
        end
        CMD_PRE: begin
          cut = r_reg.w_active || r_reg.q_valid;
          r_next.w_active = 1'b0;
          r_next.q_valid = 1'b0;
          if (r_reg.s2.addr[AP_BIT]) begin
            r_next.bank_open = '0;
            r_next.rd_left = '0;
          end else begin
            r_next.bank_open[r_reg.s2.ba] = 1'b0;
            if (r_reg.rd_bank == r_reg.s2.ba) begin
              r_next.rd_left = '0;
            end
          end
        end
        CMD_BST: begin
          r_next.rd_left = '0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign push_word = {r_reg.s2.dq, cap_bank, r_reg.row[cap_bank],
                      elem_col(cap_base, idx, len, interleave)};

  ddrw_fifo #(
    .W(WORD_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(pop_word)
  );

  assign {wr_data, wr_bank, wr_row, wr_col} = pop_word;
  assign dqs_out = 1'b0;
  assign dq_out = '0;
  assign dqs_oe = r_reg.pin_oe;
  assign dq_oe = r_reg.pin_oe;
  assign bank_open = r_reg.bank_open;
  assign write_active = r_reg.w_active;
  assign read_active = (r_reg.rd_left != '0);
  assign cmd_err = r_reg.cmd_err;
  assign fifo_drop = r_reg.drop;

  sequence s_ap_done;
    wdone_ap;
  endsequence
  sequence s_ap_closed;
    ##[1:6] !r_reg.ap_busy;
  endsequence
  property p_write_ap;
    @(posedge core_clk) disable iff (!arst_n)
    s_ap_done |-> s_ap_closed;
  endproperty
  a_write_ap: assert property (p_write_ap)
    else $error("auto precharge after write did not complete");
  property p_first_rise;
    @(posedge core_clk) disable iff (!arst_n)
    (start_ev && !cut) |-> (push == !r_reg.s2.dm) ##1
      (write_active && r_reg.w_col == $past(r_reg.q_col));
  endproperty
  a_first_rise: assert property (p_first_rise)
    else $error("burst start lost its element or column");
  property p_idle_ignore;
    @(posedge core_clk) disable iff (!arst_n)
    (!r_reg.w_active && !start_ev) |-> (!push && !dq_oe && !dqs_oe);
  endproperty
  a_idle_ignore: assert property (p_idle_ignore)
    else $error("data taken or pins driven outside a burst");
  property p_mask;
    @(posedge core_clk) disable iff (!arst_n)
    (take && r_reg.s2.dm) |-> !push ##1 (r_reg.w_idx == $past(idx) + 1);
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked element was written or not counted");
  property p_bst_keeps_row;
    @(posedge core_clk) disable iff (!arst_n)
    (cmd_ok && r_reg.s2.cmd == CMD_BST && !r_reg.rd_ap && !r_reg.ap_busy)
      |=> (r_reg.bank_open == $past(r_reg.bank_open) && !read_active);
  endproperty
  a_bst_keeps_row: assert property (p_bst_keeps_row)
    else $error("burst terminate changed the open rows");
  property p_pre_all;
    @(posedge core_clk) disable iff (!arst_n)
    (cmd_ok && r_reg.s2.cmd == CMD_PRE && r_reg.s2.addr[AP_BIT])
      |=> (r_reg.bank_open == '0 && !read_active);
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all left a bank open");
  property p_write_closed;
    @(posedge core_clk) disable iff (!arst_n)
    (cmd_ok && r_reg.s2.cmd == CMD_WRITE && !r_reg.bank_open[r_reg.s2.ba])
      |=> (cmd_err && !r_reg.q_valid) ##1 !cmd_err;
  endproperty
  a_write_closed: assert property (p_write_closed)
    else $error("write to a closed bank not refused");
  property p_cut;
    @(posedge core_clk) disable iff (!arst_n)
    cut |=> (!write_active && !r_reg.q_valid);
  endproperty
  a_cut: assert property (p_cut)
    else $error("write burst survived a read or precharge");
  property p_len;
    @(posedge core_clk) disable iff (!arst_n)
    write_active |-> (r_reg.w_idx < r_reg.w_len &&
                      (r_reg.w_len == BL_2 || r_reg.w_len == BL_4 ||
                       r_reg.w_len == BL_8));
  endproperty
  a_len: assert property (p_len)
    else $error("burst index outside programmed length");
endmodule

`default_nettype wire

// ### logic/ddrw_pkg.sv
// Purpose: Shared constants and types for the DDR write-burst receiver.
// Assumes: Core clock of 40 ns; link pins sampled, never used as clocks.
// Notes: Command code is {cs_n, ras_n, cas_n, we_n}.
// Contract
// - WRITE carries bank, column, auto precharge choice
// - Write auto precharge after burst plus recovery
// - First element on first strobe rise
// - After burst, pins undriven, extra data ignored
// - New WRITE any edge, concatenates or truncates
// - READ truncation keeps only earlier pairs
// - PRECHARGE truncation keeps only earlier pairs
// - BURST TERMINATE stops read, row stays open
// - Read auto precharge at half burst length
// - PRECHARGE two clocks after READ cuts burst
// - Burst length 2, 4, 8 in programmed order
// - Address bit 10 selects write auto precharge
// - WRITE encoding, accepted only on open row
// - PRECHARGE bit 10 selects all or one bank
`default_nettype none

package ddrw_pkg;
  localparam int unsigned CORE_NS = 40;
  localparam int unsigned DQ_W = 8;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned BA_W = 2;
  localparam int unsigned COL_W = 10;
  localparam int unsigned NBANK = 4;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned WORD_W = DQ_W + BA_W + ADDR_W + COL_W;

  // Write recovery and minimum active time, least times rounded up
  localparam int unsigned TWR_NS = 15;
  localparam int unsigned TWR_RAW = (TWR_NS + CORE_NS - 1) / CORE_NS;
  localparam int unsigned TWR_CYC = (TWR_RAW < 1) ? 1 : TWR_RAW;
  localparam int unsigned TRAS_NS = 40;
  localparam int unsigned TRAS_RAW = (TRAS_NS + CORE_NS - 1) / CORE_NS;
  localparam int unsigned TRAS_CYC = (TRAS_RAW < 1) ? 1 : TRAS_RAW;

  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_BST = 4'h6;

  localparam logic [1:0] BL_CODE_2 = 2'h1;
  localparam logic [1:0] BL_CODE_4 = 2'h2;
  localparam logic [1:0] BL_CODE_8 = 2'h3;
  localparam logic [CNT_W-1:0] BL_2 = 4'h2;
  localparam logic [CNT_W-1:0] BL_4 = 4'h4;
  localparam logic [CNT_W-1:0] BL_8 = 4'h8;

  typedef struct packed {
    logic ck;
    logic cke;
    logic [3:0] cmd;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic dqs;
    logic [DQ_W-1:0] dq;
    logic dm;
  } pins_s;
endpackage

`default_nettype wire

// ### logic/ddrw_fifo.sv
// Purpose: Small FIFO between the strobe capture and the user stream.
// Assumes: One clock; push and pop may share a cycle.
// Notes: Read data come straight from the storage registers.
`default_nettype none

module ddrw_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned PW = (D > 1) ? $clog2(D) : 1;
  localparam int unsigned CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_s;

  fifo_s r_reg, r_next;
  logic do_push, do_pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready = (r_reg.cnt != CW'(D));
  assign out_valid = (r_reg.cnt != '0);
  assign out_data = r_reg.mem[r_reg.rp];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    r_next = r_reg;
    if (do_push) begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp = ptr_inc(r_reg.wp);
    end
    if (do_pop) begin
      r_next.rp = ptr_inc(r_reg.rp);
    end
    if (do_push && !do_pop) begin
      r_next.cnt = CW'(r_reg.cnt + 1'b1);
    end else if (do_pop && !do_push) begin
      r_next.cnt = CW'(r_reg.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

`default_nettype wire

// ### verification/ddrw_ctrl_model.sv
// Purpose: Behavioural memory controller driving commands and write data.
// Assumes: Free-running link clock, 320 ns, offset from the core clock.
// Notes: Bench queues one command per link clock and the data elements.
`default_nettype none

module ddrw_ctrl_model
  import ddrw_pkg::*;
(
  // Link command pins
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  // Link data pins
  output logic dqs,
  output logic [DQ_W-1:0] dq,
  output logic dm,
  // Model state
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [ADDR_W+BA_W+3:0] cq[$];
  logic [DQ_W:0] eq[$];
  logic [ADDR_W+BA_W+3:0] c;
  int pend = 0;
  bit run = 1'b0;
  bit have = 1'b0;

  task automatic cmd(input logic [3:0] op, input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] a);
    cq.push_back({op, b, a});
    busy = 1'b1;
  endtask

  task automatic put(input logic [DQ_W-1:0] d, input logic m);
    eq.push_back({m, d});
    busy = 1'b1;
  endtask

  // One link half period: edge, then next element a quarter later
  task automatic half(input logic lvl);
    ck = lvl;
    if (!lvl) begin
      c = (cq.size() > 0) ? cq.pop_front() : {4'h7, BA_W'(0), ADDR_W'(0)};
      {cs_n, ras_n, cas_n, we_n, ba, addr} = c;
      if (c[ADDR_W+BA_W+:4] == CMD_WRITE && !run && pend == 0)
        pend = 4;
    end
    if (pend > 0)
      pend--;
    // strobe low around bursts, no gaps
    if (have) begin
      dqs = ~dqs;
      run = 1'b1;
    end else if (run || pend > 0) begin
      dqs = 1'b0;
      run = 1'b0;
    end else
      dqs = ~dqs;
    busy = cq.size() > 0 || eq.size() > 0 || run || pend > 0;
    #80;
    have = (run || pend == 1) && eq.size() > 0;
    if (have)
      {dm, dq} = eq.pop_front();
    else begin
      dq = ~dq;
      dm = ~dm;
    end
    #80;
  endtask

  initial begin
    ck = 1'b0;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = '0;
    addr = '0;
    dqs = 1'b0;
    dq = '0;
    dm = 1'b0;
    busy = 1'b0;
    #7;
    forever begin
      half(1'b1);
      half(1'b0);
    end
  end
endmodule

`default_nettype wire

// ### verification/ddr_write_burst_sequencing_bench.sv
// Purpose: Self-checking bench for the DDR write-burst receiver.
// Assumes: Controller model drives the link; 40 ns core clock.
// Notes: Words leaving the FIFO are collected and compared in order.
`default_nettype none

module ddr_write_burst_sequencing_bench
  import ddrw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] NOP = 4'h7;
  localparam logic [ADDR_W-1:0] AP = ADDR_W'(1) << AP_BIT;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_ready = 1'b1;
  logic [1:0] bl_code = BL_CODE_4;
  logic interleave = 1'b0;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, dqs_m, dm, busy;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_m, dq_out, wr_data;
  logic dqs_out, dqs_oe, dq_oe, wr_valid, write_active, read_active;
  logic cmd_err, fifo_drop;
  logic [BA_W-1:0] wr_bank;
  logic [ADDR_W-1:0] wr_row;
  logic [COL_W-1:0] wr_col;
  logic [NBANK-1:0] bank_open;
  wire logic dqs_pin = (dqs_oe === 1'b1) ? dqs_out : dqs_m;
  wire logic [DQ_W-1:0] dq_pin = (dq_oe === 1'b1) ? dq_out : dq_m;
  logic [WORD_W-1:0] got[$];
  logic [WORD_W-1:0] exp[$];
  int fails = 0;
  int n_checks = 0;
  int drops = 0;
  int errs = 0;
  int bl_n = 4;
  logic ilv_n = 1'b0;

  always #20 core_clk = ~core_clk;

  ddrw_ctrl_model i_ddrw_ctrl_model (.ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .dqs(dqs_m), .dq(dq_m), .dm(dm), .busy(busy));

  ddrw_top i_ddrw_top (.core_clk(core_clk), .arst_n(arst_n), .ck(ck),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dqs_in(dqs_pin), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe), .dq_in(dq_pin), .dq_out(dq_out), .dq_oe(dq_oe),
    .dm(dm), .bl_code(bl_code), .interleave(interleave),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .wr_bank(wr_bank), .wr_row(wr_row), .wr_col(wr_col),
    .bank_open(bank_open), .write_active(write_active),
    .read_active(read_active), .cmd_err(cmd_err), .fifo_drop(fifo_drop));

  always @(posedge core_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      got.push_back({wr_bank, wr_row, wr_col, wr_data});
    if (fifo_drop === 1'b1)
      drops++;
    if (cmd_err === 1'b1)
      errs++;
  end

  task automatic finish_test();
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] e);
    n_checks++;
    if (a !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask

  function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] b,
      input int i, input int n, input logic ilv);
    logic [COL_W-1:0] m;
    m = COL_W'(n - 1);
    col_of = ilv ? (b ^ COL_W'(i)) : ((b & ~m) | ((b + COL_W'(i)) & m));
  endfunction

  task automatic cfg(input logic [1:0] code, input int n, input logic ilv);
    @(posedge core_clk);
    bl_code <= code;
    interleave <= ilv;
    bl_n = n;
    ilv_n = ilv;
  endtask

  task automatic c(input logic [3:0] op, input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] a);
    i_ddrw_ctrl_model.cmd(op, b, a);
  endtask

  // Queue k elements and the words the unmasked ones should give
  task automatic burst(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] r,
      input logic [COL_W-1:0] col, input int k, input logic [7:0] d0,
      input logic [7:0] msk);
    logic [DQ_W-1:0] d;
    for (int i = 0; i < k; i++) begin
      d = d0 + DQ_W'(i);
      i_ddrw_ctrl_model.put(d, msk[i]);
      if (!msk[i])
        exp.push_back({b, r, col_of(col, i, bl_n, ilv_n), d});
    end
  endtask

  task automatic settle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    chk(WORD_W'(k < 4000), 33'h1);
    repeat (24) @(posedge core_clk);
  endtask

  task automatic wait_rd();
    int k;
    k = 0;
    while (read_active !== 1'b1 && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    chk(WORD_W'(k < 200), 33'h1);
  endtask

  task automatic check_words();
    chk(WORD_W'(got.size()), WORD_W'(exp.size()));
    while (got.size() > 0 && exp.size() > 0)
      chk(got.pop_front(), exp.pop_front());
    got.delete();
    exp.delete();
  endtask

  task automatic s_basic();
    cfg(BL_CODE_4, 4, 1'b0);
    c(CMD_ACT, 2'h1, 13'h0123);
    c(NOP, 2'h0, 13'h0000);
    c(CMD_WRITE, 2'h1, 13'h0005);
    burst(2'h1, 13'h0123, 10'h005, 4, 8'h10, 8'h04);
    settle();
    check_words();
    chk(WORD_W'(bank_open), 33'h2);
    chk(WORD_W'({dq_oe, dqs_oe}), 33'h0);
  endtask

  task automatic s_ap();
    int k;
    int e0;
    cfg(BL_CODE_2, 2, 1'b1);
    c(CMD_WRITE, 2'h1, AP | 13'h0003);
    burst(2'h1, 13'h0123, 10'h003, 2, 8'h20, 8'h00);
    k = 0;
    while (write_active !== 1'b1 && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    chk(WORD_W'(k < 200), 33'h1);
    chk(WORD_W'(bank_open[1]), 33'h1);
    settle();
    check_words();
    chk(WORD_W'(bank_open), 33'h0);
    e0 = errs;
    c(CMD_WRITE, 2'h1, 13'h0000);
    settle();
    chk(WORD_W'(errs - e0), 33'h1);
    check_words();
  endtask

  task automatic s_trunc();
    cfg(BL_CODE_8, 8, 1'b1);
    c(CMD_ACT, 2'h2, 13'h00aa);
    c(CMD_ACT, 2'h3, 13'h01f0);
    c(CMD_WRITE, 2'h2, 13'h001d);
    c(CMD_WRITE, 2'h3, 13'h0043);
    burst(2'h2, 13'h00aa, 10'h01d, 2, 8'h30, 8'h00);
    burst(2'h3, 13'h01f0, 10'h043, 8, 8'h40, 8'h00);
    settle();
    check_words();
  endtask

  task automatic s_rdcut();
    c(CMD_WRITE, 2'h2, 13'h0010);
    c(NOP, 2'h0, 13'h0000);
    // one clock of delay, pairs after the first masked
    c(NOP, 2'h0, 13'h0000);
    c(CMD_READ, 2'h2, 13'h0000);
    c(CMD_BST, 2'h0, 13'h0000);
    burst(2'h2, 13'h00aa, 10'h010, 8, 8'h50, 8'hfc);
    wait_rd();
    repeat (22) @(posedge core_clk);
    chk(WORD_W'(read_active), 33'h0);
    settle();
    check_words();
    chk(WORD_W'(bank_open[2]), 33'h1);
  endtask

  task automatic s_pre();
    c(CMD_ACT, 2'h0, 13'h0055);
    c(NOP, 2'h0, 13'h0000);
    c(CMD_WRITE, 2'h0, 13'h0008);
    c(NOP, 2'h0, 13'h0000);
    c(NOP, 2'h0, 13'h0000);
    c(CMD_PRE, 2'h0, 13'h0000);
    burst(2'h0, 13'h0055, 10'h008, 8, 8'h60, 8'hfc);
    settle();
    check_words();
    chk(WORD_W'(bank_open), 33'hc);
    c(CMD_ACT, 2'h0, 13'h0055);
    c(NOP, 2'h0, 13'h0000);
    c(CMD_READ, 2'h0, 13'h0000);
    c(NOP, 2'h0, 13'h0000);
    c(CMD_PRE, 2'h3, AP);
    wait_rd();
    repeat (22) @(posedge core_clk);
    chk(WORD_W'(read_active), 33'h0);
    chk(WORD_W'(bank_open), 33'h0);
    settle();
  endtask

  task automatic s_rdap();
    cfg(BL_CODE_2, 2, 1'b0);
    c(CMD_ACT, 2'h2, 13'h0007);
    c(NOP, 2'h0, 13'h0000);
    c(CMD_READ, 2'h2, AP);
    wait_rd();
    chk(WORD_W'(bank_open), 33'h4);
    repeat (16) @(posedge core_clk);
    chk(WORD_W'(bank_open), 33'h0);
    settle();
  endtask

  task automatic s_full();
    int d0;
    cfg(BL_CODE_8, 8, 1'b0);
    wr_ready <= 1'b0;
    d0 = drops;
    c(CMD_ACT, 2'h3, 13'h0111);
    c(NOP, 2'h0, 13'h0000);
    c(CMD_WRITE, 2'h3, 13'h0000);
    burst(2'h3, 13'h0111, 10'h000, 8, 8'h70, 8'h00);
    settle();
    chk(WORD_W'(drops - d0), 33'h4);
    chk(WORD_W'(wr_valid), 33'h1);
    while (exp.size() > FIFO_DEPTH)
      void'(exp.pop_back());
    @(posedge core_clk);
    wr_ready <= 1'b1;
    repeat (8) @(posedge core_clk);
    check_words();
    chk(WORD_W'(wr_valid), 33'h0);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    s_basic();
    s_ap();
    s_trunc();
    s_rdcut();
    s_pre();
    s_rdap();
    s_full();
    finish_test();
  end

  initial begin
    #2000000;
    fails++;
    finish_test();
  end
endmodule

`default_nettype wire
